/* File: common/fsl_pkg.sv */
// Constants and types for the flash status, error and lock block
// Notes on behaviour
// - A failed or protected program/erase raises its error flag; operation counts as not done.
// - On error, program-fail or erase-fail and operation-pending go to 1 and stay there.
// - Host sends clear-status to recover; device clears errors and returns to standby.
// - Register-lock set freezes block-protect bits, nonvolatile complement and top/bottom select.
// - Write-registers with one data byte updates status one only, config one untouched.
// - Autoboot and bank-address opcodes are not decoded; host must not use them.
// - No hold function; that pin is an active-low hardware reset input.
// - Hardware reset pin low resets the device to standby, ready for commands.
package fsl_pkg;
    // Serial opcodes
    localparam logic [7:0] OPC_WRITE_REGS = 8'h01;
    localparam logic [7:0] OPC_RDSR = 8'h05;
    localparam logic [7:0] OPC_WREN = 8'h06;
    localparam logic [7:0] OPC_CLSR = 8'h30;
    localparam logic [7:0] OPC_RDCR = 8'h35;
    // Status one bit positions
    localparam int SR_OP_PENDING = 0;
    localparam int SR_WEL = 1;
    localparam int SR_PERR = 6;
    localparam int SR_EERR = 7;
    localparam int SR_TB = 6;
    // Config one bit positions
    localparam int CR_LOCK = 0;
    localparam int CR_QUAD = 1;
    localparam int CR_CMP = 6;
    // Write masks
    localparam logic [7:0] SRV_WMASK = 8'h3C;
    localparam logic [7:0] SRNV_WMASK = 8'h7C;
    localparam logic [7:0] CR_WMASK = 8'h42;
    localparam logic [7:0] CR_LOCKED_MASK = 8'h40;
    // Reset values
    localparam logic [7:0] SRNV_RST = 8'h00;
    localparam logic [7:0] CRNV_RST = 8'h00;
    // Pin sync flops start at idle levels; sck idles low so reset makes no false edge
    localparam logic [3:0] PIN_IDLE = 4'hE;
    // APB map
    localparam logic [11:0] ADDR_STATUS = 12'h000;
    localparam logic [11:0] ADDR_OPCMD = 12'h004;
    localparam int OP_PGM = 0;
    localparam int OP_ERS = 1;
    localparam int OP_PROT = 2;
    localparam int OP_FAIL = 3;
    // Timing
    localparam int CLK_NS = 40;
    localparam int OP_TIME_NS = 2000;
    localparam int OP_CYCLES = OP_TIME_NS / CLK_NS;
    localparam logic [7:0] OP_CNT_INIT = 8'(OP_CYCLES);

    typedef struct packed {
        logic [7:0] cr_nv;
        logic [7:0] cr_v;
        logic [7:0] sr_nv;
        logic [7:0] sr_v;
    } fsl_regs_t;

    typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_DATA, ST_READ, ST_SKIP} fsl_state_t;
endpackage : fsl_pkg

/* File: design/fsl_status_lock.sv */
// Serial flash status, error flags and register lock with APB view
`timescale 1ns/1ps
`default_nettype none
module fsl_status_lock (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic si_i,
    input wire logic reset_n_pin_i,
    output logic so_o,
    output logic so_oe_n_o
);
    ////////////////////////////////////////////////////////////////
    logic [1:0] rst_sync_ff;
    wire rst_n = rst_sync_ff[1];
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) rst_sync_ff <= 2'h0;
        else rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end

    // Pins: sck, cs_n, si, reset pin
    logic [3:0] pin_s1_ff;
    logic [3:0] pin_s2_ff;
    logic sck_d_ff;
    wire [3:0] pin_raw = {reset_n_pin_i, si_i, cs_n_i, sck_i};
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            always_ff @(posedge ref_clk_i or negedge rst_n) begin
                if (!rst_n) begin
                    pin_s1_ff[gi] <= fsl_pkg::PIN_IDLE[gi];
                    pin_s2_ff[gi] <= fsl_pkg::PIN_IDLE[gi];
                end else begin
                    pin_s1_ff[gi] <= pin_raw[gi];
                    pin_s2_ff[gi] <= pin_s1_ff[gi];
                end
            end
        end
    endgenerate
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) sck_d_ff <= 1'b0;
        else sck_d_ff <= pin_s2_ff[0];
    end
    wire cs_n = pin_s2_ff[1];
    wire si = pin_s2_ff[2];
    // Former hold pin serves only as reset; no pause logic exists
    wire pin_rst = !pin_s2_ff[3];
    wire sck_rise = pin_s2_ff[0] && !sck_d_ff;
    wire sck_fall = !pin_s2_ff[0] && sck_d_ff;

    ////////////////////////////////////////////////////////////////
    fsl_pkg::fsl_regs_t regs_ff;
    fsl_pkg::fsl_state_t state_ff;
    logic [2:0] bit_cnt_ff;
    logic [7:0] rx_ff;
    logic [7:0] cmd_ff;
    logic [7:0] d0_ff;
    logic [7:0] d1_ff;
    logic [1:0] nbytes_ff;
    logic [7:0] tx_ff;
    logic busy_ff;
    logic op_ers_ff;
    logic op_bad_ff;
    logic [7:0] op_cnt_ff;

    wire lock = regs_ff.cr_v[fsl_pkg::CR_LOCK];
    wire operation_pending_flag = regs_ff.sr_v[fsl_pkg::SR_OP_PENDING];
    wire wel = regs_ff.sr_v[fsl_pkg::SR_WEL];
    wire has_err = regs_ff.sr_v[fsl_pkg::SR_PERR] || regs_ff.sr_v[fsl_pkg::SR_EERR];
    wire [7:0] rx_next = {rx_ff[6:0], si};
    wire byte_done = sck_rise && (bit_cnt_ff == 3'h7);
    wire cs_rise = cs_n && (state_ff != fsl_pkg::ST_IDLE);
    wire cs_fall = !cs_n && (state_ff == fsl_pkg::ST_IDLE);

    // Commands act when chip select rises; unknown opcodes do nothing
    wire write_registers_go = cs_rise && state_ff == fsl_pkg::ST_DATA && cmd_ff == fsl_pkg::OPC_WRITE_REGS
                  && nbytes_ff != 2'h0 && wel && !operation_pending_flag;
    wire two_bytes = nbytes_ff[1];
    wire clsr_go = cs_rise && state_ff == fsl_pkg::ST_SKIP && cmd_ff == fsl_pkg::OPC_CLSR;
    wire wren_go = cs_rise && state_ff == fsl_pkg::ST_SKIP && cmd_ff == fsl_pkg::OPC_WREN
                   && !operation_pending_flag;

    // Lock turns write masks off for protected fields
    wire [7:0] srv_wm = lock ? 8'h00 : fsl_pkg::SRV_WMASK;
    wire [7:0] srnv_wm = lock ? 8'h00 : fsl_pkg::SRNV_WMASK;
    wire [7:0] cr_wm = lock ? (fsl_pkg::CR_WMASK & ~fsl_pkg::CR_LOCKED_MASK) : fsl_pkg::CR_WMASK;
    wire [7:0] srv_new = (regs_ff.sr_v & ~srv_wm) | (d0_ff & srv_wm);
    wire [7:0] srnv_new = (regs_ff.sr_nv & ~srnv_wm) | (d0_ff & srnv_wm);
    // Lock bit can be set by software, cleared only by a reset
    wire [7:0] crv_new = ((regs_ff.cr_v & ~cr_wm) | (d1_ff & cr_wm)) | {7'h00, d1_ff[fsl_pkg::CR_LOCK]};
    wire [7:0] crnv_new = (regs_ff.cr_nv & ~cr_wm) | (d1_ff & cr_wm);

    // APB decode
    wire apb_setup = psel_i && !penable_i;
    wire apb_write = psel_i && penable_i && pready_o && pwrite_i;
    wire hit_status = paddr_i == fsl_pkg::ADDR_STATUS;
    wire hit_opcmd = paddr_i == fsl_pkg::ADDR_OPCMD;
    wire apb_bad = !(hit_status || (hit_opcmd && pwrite_i));
    wire [31:0] rd_word = hit_status ? regs_ff : 32'h0000_0000;
    wire op_req = apb_write && hit_opcmd && (pwdata_i[fsl_pkg::OP_PGM] || pwdata_i[fsl_pkg::OP_ERS]);
    wire op_start = op_req && !operation_pending_flag && wel && !pin_rst;
    wire op_end = busy_ff && op_cnt_ff == 8'h01;

    ////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end else begin
            pready_o <= apb_setup;
            pslverr_o <= apb_setup && apb_bad;
            prdata_o <= apb_setup ? rd_word : 32'h0000_0000;
        end
    end

    // Serial front end
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= fsl_pkg::ST_IDLE;
            bit_cnt_ff <= 3'h0;
            rx_ff <= 8'h00;
            cmd_ff <= 8'h00;
            d0_ff <= 8'h00;
            d1_ff <= 8'h00;
            nbytes_ff <= 2'h0;
            tx_ff <= 8'h00;
            so_o <= 1'b0;
            so_oe_n_o <= 1'b1;
        end else if (pin_rst || cs_rise) begin
            state_ff <= fsl_pkg::ST_IDLE;
            so_oe_n_o <= 1'b1;
        end else if (cs_fall) begin
            state_ff <= fsl_pkg::ST_CMD;
            bit_cnt_ff <= 3'h0;
            nbytes_ff <= 2'h0;
        end else begin
            if (sck_rise) begin
                rx_ff <= rx_next;
                bit_cnt_ff <= bit_cnt_ff + 3'h1;
            end
            if (sck_fall && state_ff == fsl_pkg::ST_READ) begin
                so_o <= tx_ff[7];
                tx_ff <= {tx_ff[6:0], 1'b0};
                so_oe_n_o <= 1'b0;
            end
            if (byte_done) begin
                unique case (state_ff)
                    fsl_pkg::ST_CMD: begin
                        cmd_ff <= rx_next;
                        if (rx_next == fsl_pkg::OPC_WRITE_REGS) state_ff <= fsl_pkg::ST_DATA;
                        else if (rx_next == fsl_pkg::OPC_RDSR || rx_next == fsl_pkg::OPC_RDCR) begin
                            state_ff <= fsl_pkg::ST_READ;
                            tx_ff <= (rx_next == fsl_pkg::OPC_RDSR) ? regs_ff.sr_v : regs_ff.cr_v;
                        end else state_ff <= fsl_pkg::ST_SKIP;
                    end
                    fsl_pkg::ST_DATA: begin
                        if (nbytes_ff == 2'h0) d0_ff <= rx_next;
                        else if (nbytes_ff == 2'h1) d1_ff <= rx_next;
                        if (!nbytes_ff[1]) nbytes_ff <= nbytes_ff + 2'h1;
                    end
                    fsl_pkg::ST_READ: tx_ff <= (cmd_ff == fsl_pkg::OPC_RDSR) ? regs_ff.sr_v : regs_ff.cr_v;
                    fsl_pkg::ST_SKIP: state_ff <= fsl_pkg::ST_SKIP;
                    fsl_pkg::ST_IDLE: state_ff <= fsl_pkg::ST_IDLE;
                endcase
            end
        end
    end

    // Embedded program/erase model and status registers
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            regs_ff <= '{cr_nv: fsl_pkg::CRNV_RST, cr_v: fsl_pkg::CRNV_RST, sr_nv: fsl_pkg::SRNV_RST,
                         sr_v: fsl_pkg::SRNV_RST & fsl_pkg::SRV_WMASK};
            busy_ff <= 1'b0;
            op_ers_ff <= 1'b0;
            op_bad_ff <= 1'b0;
            op_cnt_ff <= 8'h00;
        end else if (pin_rst) begin
            // Volatile copies reload from nonvolatile, operation aborted
            regs_ff.sr_v <= regs_ff.sr_nv & fsl_pkg::SRV_WMASK;
            regs_ff.cr_v <= {regs_ff.cr_nv[7:1], 1'b0};
            busy_ff <= 1'b0;
            op_cnt_ff <= 8'h00;
        end else begin
            if (op_start) begin
                busy_ff <= 1'b1;
                op_ers_ff <= pwdata_i[fsl_pkg::OP_ERS];
                op_bad_ff <= pwdata_i[fsl_pkg::OP_PROT] || pwdata_i[fsl_pkg::OP_FAIL];
                op_cnt_ff <= fsl_pkg::OP_CNT_INIT;
                regs_ff.sr_v[fsl_pkg::SR_OP_PENDING] <= 1'b1;
            end else if (busy_ff) begin
                op_cnt_ff <= op_cnt_ff - 8'h01;
            end
            if (wren_go) regs_ff.sr_v[fsl_pkg::SR_WEL] <= 1'b1;
            if (write_registers_go) begin
                regs_ff.sr_v <= srv_new;
                regs_ff.sr_nv <= srnv_new;
                regs_ff.sr_v[fsl_pkg::SR_WEL] <= 1'b0;
                if (two_bytes) begin
                    regs_ff.cr_v <= crv_new;
                    regs_ff.cr_nv <= crnv_new;
                end
            end
            if (clsr_go && has_err) begin
                regs_ff.sr_v[fsl_pkg::SR_PERR] <= 1'b0;
                regs_ff.sr_v[fsl_pkg::SR_EERR] <= 1'b0;
                regs_ff.sr_v[fsl_pkg::SR_OP_PENDING] <= 1'b0;
                regs_ff.sr_v[fsl_pkg::SR_WEL] <= 1'b0;
            end
            // Completion after clear so a set always wins
            if (op_end) begin
                busy_ff <= 1'b0;
                if (op_bad_ff) begin
                    regs_ff.sr_v[fsl_pkg::SR_EERR] <= op_ers_ff;
                    regs_ff.sr_v[fsl_pkg::SR_PERR] <= !op_ers_ff;
                    regs_ff.sr_v[fsl_pkg::SR_OP_PENDING] <= 1'b1;
                end else begin
                    regs_ff.sr_v[fsl_pkg::SR_OP_PENDING] <= 1'b0;
                    regs_ff.sr_v[fsl_pkg::SR_WEL] <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    sequence s_busy_run;
        operation_pending_flag [*8];
    endsequence
    property p_start_busy;
        // A hardware reset aborts the operation, so it cancels this check
        @(posedge ref_clk_i) disable iff (!rst_n || pin_rst) op_start |=> s_busy_run;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("pending flag not held after start");
    property p_err_set;
        @(posedge ref_clk_i) disable iff (!rst_n)
            op_end && op_bad_ff && !pin_rst |=> has_err && operation_pending_flag;
    endproperty
    a_err_set: assert property (p_err_set) else $error("failed operation did not flag error");
    property p_err_sticky;
        @(posedge ref_clk_i) disable iff (!rst_n)
            has_err && !clsr_go && !pin_rst |=> has_err && operation_pending_flag;
    endproperty
    a_err_sticky: assert property (p_err_sticky) else $error("error flag dropped without clear");
    property p_clsr;
        @(posedge ref_clk_i) disable iff (!rst_n)
            clsr_go && has_err && !pin_rst |=> !has_err && !operation_pending_flag;
    endproperty
    a_clsr: assert property (p_clsr) else $error("clear status left error set");
    property p_lock_bp;
        @(posedge ref_clk_i) disable iff (!rst_n)
            lock && write_registers_go && !pin_rst |=> $stable(regs_ff.sr_v[5:2]) && $stable(regs_ff.sr_nv[6:2]);
    endproperty
    a_lock_bp: assert property (p_lock_bp) else $error("protect bits changed under lock");
    property p_lock_cmp;
        @(posedge ref_clk_i) disable iff (!rst_n)
            lock && write_registers_go && !pin_rst |=> $stable(regs_ff.cr_nv[fsl_pkg::CR_CMP]) && lock;
    endproperty
    a_lock_cmp: assert property (p_lock_cmp) else $error("complement bit changed under lock");
    property p_one_byte;
        @(posedge ref_clk_i) disable iff (!rst_n)
            write_registers_go && !two_bytes && !pin_rst |=> $stable(regs_ff.cr_v) && $stable(regs_ff.cr_nv);
    endproperty
    a_one_byte: assert property (p_one_byte) else $error("single byte write touched config");
    property p_pin_rst;
        @(posedge ref_clk_i) disable iff (!rst_n)
            pin_rst |=> state_ff == fsl_pkg::ST_IDLE && !operation_pending_flag && !busy_ff && so_oe_n_o;
    endproperty
    a_pin_rst: assert property (p_pin_rst) else $error("hardware reset did not reach standby");
endmodule : fsl_status_lock
`default_nettype wire

/* File: test/fsl_spi_host_model.sv */
// SPI host model that clocks mode 0 command frames into the status block
`timescale 1ns/1ps
`default_nettype none
module fsl_spi_host_model (
    input wire logic clk_i,
    input wire logic so_i,
    input wire logic so_oe_n_i,
    output logic sck_o,
    output logic cs_n_o,
    output logic si_o
);
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Opcode, nb write bytes from wd, nr read bytes; 8 clk per sck period
    task automatic frame(input logic [7:0] op, input int nb, input logic [15:0] wd, input int nr,
            output logic [7:0] rd, output logic drove);
        logic [31:0] sh;
        sh = {op, wd, 8'h00};
        drove = 1'b0;
        rd = 8'h00;
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        for (int i = 0; i < 8 * (1 + nb + nr); i++) begin
            si_o <= sh[31 - i];
            repeat (4) @(posedge clk_i);
            sck_o <= 1'b1;
            repeat (4) @(posedge clk_i);
            // Late sample: so lags the pin by the sync stages
            // Undriven line reads as the inverse of its last bit
            rd = {rd[6:0], so_oe_n_i ? ~so_i : so_i};
            drove = drove | ~so_oe_n_i;
            sck_o <= 1'b0;
        end
        repeat (4) @(posedge clk_i);
        cs_n_o <= 1'b1;
        // Released line toggles so a stale bit never reads as data
        si_o <= ~si_o;
        repeat (8) @(posedge clk_i);
    endtask : frame
endmodule : fsl_spi_host_model
`default_nettype wire

/* File: test/tb.sv */
// Self-checking bench for the flash status, error and lock block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin mismatches++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module tb;
    logic ref_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic reset_n_pin = 1'b1;
    logic [31:0] prdata, v;
    logic pready, pslverr, sck, cs_n, si, so, so_oe_n, err, dr;
    logic [7:0] rd;
    int mismatches = 0;
    int checked = 0;
    always #20 ref_clk_i = ~ref_clk_i;
    fsl_status_lock dut_u (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .sck_i(sck), .cs_n_i(cs_n), .si_i(si), .reset_n_pin_i(reset_n_pin),
        .so_o(so), .so_oe_n_o(so_oe_n));
    fsl_spi_host_model host_u (.clk_i(ref_clk_i), .so_i(so), .so_oe_n_i(so_oe_n), .sck_o(sck),
        .cs_n_o(cs_n), .si_o(si));
    ////////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("Counts: checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk_i);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (pready !== 1'b1 && n < 16);
        v = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            mismatches++;
            results();
        end
    endtask : apb
    task automatic st();
        apb(1'b0, fsl_pkg::ADDR_STATUS, 32'h0);
        `CHK("status slverr", 1'b0, err)
    endtask : st
    task automatic sp(input logic [7:0] op, input int nb, input logic [15:0] wd, input int nr);
        host_u.frame(op, nb, wd, nr, rd, dr);
    endtask : sp
    task automatic write_regs(input int nb, input logic [15:0] wd);
        sp(fsl_pkg::OPC_WREN, 0, 16'h0000, 0);
        sp(fsl_pkg::OPC_WRITE_REGS, nb, wd, 0);
    endtask : write_regs
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        st();
        `CHK("reset status", 32'h0, v)
        apb(1'b0, 12'h008, 32'h0);
        `CHK("unmapped read", 1'b1, err)
        apb(1'b1, 12'h00C, 32'h1);
        `CHK("unmapped write", 1'b1, err)
        apb(1'b0, fsl_pkg::ADDR_OPCMD, 32'h0);
        `CHK("opcmd read", 1'b1, err)
        $display("t_regs done");
    endtask : t_regs
    task automatic t_wrr();
        write_regs(2, 16'h0002);
        // Unenabled write is refused but leaves a stale config byte behind
        sp(fsl_pkg::OPC_WRITE_REGS, 2, 16'h00C2, 0);
        write_regs(1, 16'h1C00);
        st();
        `CHK("sr_v bp", 8'h1C, v[7:0] & fsl_pkg::SRV_WMASK)
        `CHK("sr_nv bp", 8'h1C, v[15:8] & fsl_pkg::SRNV_WMASK)
        `CHK("cr_v kept", 8'h02, v[23:16])
        `CHK("cr_nv kept", 8'h02, v[31:24] & fsl_pkg::CR_WMASK)
        sp(fsl_pkg::OPC_RDCR, 0, 16'h0000, 1);
        `CHK("config on so", 8'h02, rd)
        `CHK("so driven", 1'b1, dr)
        sp(fsl_pkg::OPC_RDSR, 0, 16'h0000, 1);
        `CHK("status on so", 8'h1C, rd)
        $display("t_wrr done");
    endtask : t_wrr
    task automatic t_lock();
        write_regs(2, 16'h1C43);
        write_regs(2, 16'h6000);
        st();
        `CHK("sr_v frozen", 8'h1C, v[7:0] & fsl_pkg::SRV_WMASK)
        `CHK("sr_nv frozen", 8'h1C, v[15:8] & fsl_pkg::SRNV_WMASK)
        `CHK("cr_v frozen", 8'h41, v[23:16] & 8'h43)
        `CHK("cr_nv frozen", 8'h40, v[31:24] & 8'h40)
        $display("t_lock done");
    endtask : t_lock
    task automatic t_pin();
        @(posedge ref_clk_i);
        reset_n_pin <= 1'b0;
        repeat (6) @(posedge ref_clk_i);
        reset_n_pin <= 1'b1;
        repeat (6) @(posedge ref_clk_i);
        st();
        `CHK("sr_v reload", 8'h1C, v[7:0])
        `CHK("cr_v reload", 8'h40, v[23:16] & 8'h43)
        write_regs(2, 16'h0000);
        st();
        `CHK("unlocked bp", 8'h00, v[7:0] & fsl_pkg::SRV_WMASK)
        `CHK("unlocked cmp", 1'b0, v[16 + fsl_pkg::CR_CMP])
        $display("t_pin done");
    endtask : t_pin
    task automatic t_legacy();
        // Stand-ins for retired opcodes; values are arbitrary
        logic [7:0] ops [4] = '{8'h14, 8'h15, 8'h16, 8'h17};
        foreach (ops[i]) begin
            sp(ops[i], 1, 16'hFF00, 1);
            `CHK("no answer", 1'b0, dr)
        end
        st();
        `CHK("status kept", 8'h00, v[7:0] & 8'hFD)
        $display("t_legacy done");
    endtask : t_legacy
    task automatic t_ops();
        logic [31:0] cmd [3] = '{32'h9, 32'h6, 32'h1};
        logic [7:0] ex [3] = '{8'h41, 8'h81, 8'h00};
        for (int i = 0; i < 3; i++) begin
            sp(fsl_pkg::OPC_WREN, 0, 16'h0000, 0);
            st();
            `CHK("enabled", 1'b1, v[fsl_pkg::SR_WEL])
            apb(1'b1, fsl_pkg::ADDR_OPCMD, cmd[i]);
            st();
            `CHK("busy", 1'b1, v[fsl_pkg::SR_OP_PENDING])
            repeat (fsl_pkg::OP_CYCLES + 10) @(posedge ref_clk_i);
            st();
            `CHK("outcome", ex[i], v[7:0] & 8'hC1)
            repeat (100) @(posedge ref_clk_i);
            st();
            `CHK("sticky", ex[i], v[7:0] & 8'hC1)
            sp(fsl_pkg::OPC_CLSR, 0, 16'h0000, 0);
            st();
            `CHK("cleared", 8'h00, v[7:0] & 8'hC1)
        end
        $display("t_ops done");
    endtask : t_ops
    initial begin
        repeat (6) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        t_regs();
        t_wrr();
        t_lock();
        t_pin();
        t_legacy();
        t_ops();
        results();
    end
endmodule : tb
`default_nettype wire
